// [sec_pkg.sv]
// Operation
// - store 64 words of 16 bits
// - seven instructions, nine bits each, serially
// - start bit, opcode, address, then data
// - stopped shift clock keeps all state
// - only read and status drive data out
// - dummy zero precedes the 16 data bits
// - output changes on shift clock rise
// - read continues to next word, wrapping
// - programming disabled after power-up
// - enable holds until disable or power-off
// - enable and disable do not affect reads
// - programming commands ignored while disabled
// - write stores 16 data bits
// - write erases word before programming
// - select fall starts the programming cycle
// - status shown on output after 250 ns
// - select, input high, clock rise clear status
// - disable blocks programming until re-enabled
// - erase reports status like write
// - last 16 bits received form data
// - opcode and upper address select command
package sec_pkg;
  localparam int WORD_W     = 16;
  localparam int ADDR_W     = 6;
  localparam int WORDS      = 64;
  localparam int FIFO_DEPTH = 16;

  // opcodes and extended sub-commands
  localparam logic [1:0] OPC_EXT     = 2'h0;
  localparam logic [1:0] OPC_WRITE   = 2'h1;
  localparam logic [1:0] OPC_READ    = 2'h2;
  localparam logic [1:0] OPC_ERASE   = 2'h3;
  localparam logic [1:0] SUB_DISABLE = 2'h0;
  localparam logic [1:0] SUB_FILL    = 2'h1;
  localparam logic [1:0] SUB_CLEAR   = 2'h2;
  localparam logic [1:0] SUB_ENABLE  = 2'h3;

  // address range, erased value, dummy bit, bit counts
  localparam logic [ADDR_W-1:0] ADDR_FIRST  = 6'h00;
  localparam logic [ADDR_W-1:0] ADDR_LAST   = 6'h3F;
  localparam logic [WORD_W-1:0] ERASED_WORD = 16'hFFFF;
  localparam logic              DUMMY_BIT   = 1'h0;
  localparam logic [3:0]        OPC_END     = 4'h1;
  localparam logic [3:0]        ADDR_END    = 4'h5;
  localparam logic [3:0]        WORD_END    = 4'hF;

  // timing
  localparam int CLK_NS      = 20;
  localparam int STATUS_NS   = 250;
  localparam int STATUS_CYC  = (STATUS_NS + CLK_NS - 1) / CLK_NS;
  localparam int PROG_NS_DEF = 2000000;

  typedef enum logic [1:0] {
    PK_WRITE = 2'b00,
    PK_ERASE = 2'b01,
    PK_FILL  = 2'b10,
    PK_CLEAR = 2'b11
  } sec_kind_t;

  typedef struct packed {
    sec_kind_t         kind;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] data;
  } sec_cmd_t;

  localparam int CMD_W = $bits(sec_cmd_t);

  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_OPC  = 3'b001,
    D_ADDR = 3'b010,
    D_DATA = 3'b011,
    D_FALL = 3'b100,
    D_READ = 3'b101,
    D_DONE = 3'b110
  } sec_dec_t;

  typedef enum logic [1:0] {
    E_IDLE  = 2'b00,
    E_ERASE = 2'b01,
    E_WAIT  = 2'b10,
    E_PROG  = 2'b11
  } sec_eng_t;
endpackage : sec_pkg

// [sec_prog_if.sv]
`timescale 1ns/1ns
// programming command stream between decoder, queue and engine
interface sec_prog_if #(parameter int W = 24) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : sec_prog_if

// [sec_mem.sv]
`timescale 1ns/1ns
module sec_mem #(
  parameter int W     = sec_pkg::WORD_W,
  parameter int DEPTH = sec_pkg::WORDS,
  parameter int AW    = sec_pkg::ADDR_W
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  // read port, one cycle latency
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);
  // array is not reset: its contents survive like the cells they model
  logic [W-1:0] cells [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      cells[waddr] <= wdata;
    end
  end

  // registered read data
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= '0;
    end else begin
      rdata <= cells[raddr];
    end
  end
endmodule : sec_mem

// [sec_fifo.sv]
`timescale 1ns/1ns
module sec_fifo #(
  parameter int W     = sec_pkg::CMD_W,
  parameter int DEPTH = sec_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // filling and draining sides
  sec_prog_if.snk   in_p,
  sec_prog_if.src   out_p
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] slots [DEPTH];
  logic [AW:0]  wr_ptr_reg;
  logic [AW:0]  rd_ptr_reg;
  wire          empty = wr_ptr_reg == rd_ptr_reg;
  wire          full  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                        (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  wire          push  = in_p.valid & ~full;
  wire          pop   = out_p.ready & ~empty;

  // handshake flags
  assign in_p.ready  = ~full;
  assign out_p.valid = ~empty;
  assign out_p.data  = slots[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      slots[wr_ptr_reg[AW-1:0]] <= in_p.data;
    end
  end

  // extra pointer bit tells full from empty
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + (AW+1)'(push);
      rd_ptr_reg <= rd_ptr_reg + (AW+1)'(pop);
    end
  end
endmodule : sec_fifo

// [sec_port.sv]
`timescale 1ns/1ns
module sec_port #(
  parameter int PROG_NS = sec_pkg::PROG_NS_DEF
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  // serial pins from the host
  input  wire logic select_pin,
  input  wire logic shift_clock,
  input  wire logic serial_in,
  // serial output pin
  output logic      serial_out,
  output logic      serial_out_oe,
  // state seen by the surrounding chip
  output logic      prog_enabled,
  output logic      prog_busy
);
  import sec_pkg::*;

  localparam int          PROG_CYC_I = (PROG_NS / CLK_NS < 1) ? 1 :
                                       PROG_NS / CLK_NS;
  localparam logic [31:0] PROG_LAST  = 32'(PROG_CYC_I - 1);
  localparam logic [3:0]  STATUS_END = 4'(STATUS_CYC);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic sel_s1_reg;
  logic sel_s2_reg;
  logic sel_s3_reg;
  logic shift_s1_reg;
  logic shift_s2_reg;
  logic shift_s3_reg;
  logic din_s1_reg;
  logic din_s2_reg;

  // all pins take the same two stages so data and clock stay aligned
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sel_s1_reg   <= 1'b0;
      sel_s2_reg   <= 1'b0;
      sel_s3_reg   <= 1'b0;
      shift_s1_reg <= 1'b0;
      shift_s2_reg <= 1'b0;
      shift_s3_reg <= 1'b0;
      din_s1_reg   <= 1'b0;
      din_s2_reg   <= 1'b0;
    end else begin
      sel_s1_reg   <= select_pin;
      sel_s2_reg   <= sel_s1_reg;
      sel_s3_reg   <= sel_s2_reg;
      shift_s1_reg <= shift_clock;
      shift_s2_reg <= shift_s1_reg;
      shift_s3_reg <= shift_s2_reg;
      din_s1_reg   <= serial_in;
      din_s2_reg   <= din_s1_reg;
    end
  end

  // edge events; no timeout anywhere, a parked clock just freezes state
  wire din        = din_s2_reg;
  wire shift_rise = shift_s2_reg & ~shift_s3_reg & sel_s2_reg;
  wire sel_fall = ~sel_s2_reg & sel_s3_reg;

  ////////////////////////////////////////////////////////////////////////
  // instruction decoder

  sec_dec_t            dec_state_reg;
  sec_dec_t            dec_next;
  logic [3:0]          bit_cnt_reg;
  logic [1:0]          opc_reg;
  logic [ADDR_W-1:0]   addr_reg;
  logic [WORD_W-1:0]   data_reg;
  logic                enabled_reg;
  logic                status_show_reg;
  logic [3:0]          status_age_reg;
  logic                busy_reg;

  // shift-in values, msb first
  wire [1:0]        opc_next  = {opc_reg[0], din};
  wire [ADDR_W-1:0] addr_next = {addr_reg[ADDR_W-2:0], din};
  wire [WORD_W-1:0] data_next = {data_reg[WORD_W-2:0], din};
  wire [1:0]        sub_next  = addr_next[ADDR_W-1:ADDR_W-2];
  wire [1:0]        sub_held  = addr_reg[ADDR_W-1:ADDR_W-2];

  // decode of the completed nine-bit instruction
  wire in_opc    = dec_state_reg == D_OPC;
  wire in_addr   = dec_state_reg == D_ADDR;
  wire in_data   = dec_state_reg == D_DATA;
  wire in_read   = dec_state_reg == D_READ;
  wire start_bit = shift_rise & (dec_state_reg == D_IDLE) & din;
  wire opc_done  = shift_rise & in_opc & (bit_cnt_reg == OPC_END);
  wire addr_done = shift_rise & in_addr & (bit_cnt_reg == ADDR_END);
  wire is_ext    = opc_reg == OPC_EXT;
  wire rd_start  = addr_done & (opc_reg == OPC_READ);
  wire en_set    = addr_done & is_ext & (sub_next == SUB_ENABLE);
  wire en_clr    = addr_done & is_ext & (sub_next == SUB_DISABLE);

  // programming kinds; a held-low enable sends them to D_DONE
  wire wants_data = (opc_reg == OPC_WRITE) |
                    (is_ext & (sub_next == SUB_FILL));
  wire wants_fall = (opc_reg == OPC_ERASE) |
                    (is_ext & (sub_next == SUB_CLEAR));

  // next decoder state
  always_comb begin
    dec_next = dec_state_reg;
    if (~sel_s2_reg) begin
      dec_next = D_IDLE;
    end else if (shift_rise) begin
      case (dec_state_reg)
        D_IDLE: begin
          if (din) begin
            dec_next = D_OPC;
          end
        end
        D_OPC: begin
          if (bit_cnt_reg == OPC_END) begin
            dec_next = D_ADDR;
          end
        end
        D_ADDR: begin
          if (bit_cnt_reg == ADDR_END) begin
            if (opc_reg == OPC_READ) begin
              dec_next = D_READ;
            end else if (wants_data & enabled_reg) begin
              dec_next = D_DATA;
            end else if (wants_fall & enabled_reg) begin
              dec_next = D_FALL;
            end else begin
              dec_next = D_DONE;
            end
          end
        end
        default: begin
          dec_next = dec_state_reg;
        end
      endcase
    end
  end

  // bit counter restarts at the start bit and at the opcode to address boundary
  wire [3:0] bit_cnt_next = (start_bit | opc_done) ? 4'h0 :
                            (shift_rise & (in_opc | in_addr)) ?
                            bit_cnt_reg + 4'h1 : bit_cnt_reg;

  // decoder registers; the enable latch clears only on reset or command
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      dec_state_reg <= D_IDLE;
      bit_cnt_reg   <= 4'h0;
      opc_reg       <= 2'h0;
      addr_reg      <= '0;
      data_reg      <= '0;
      enabled_reg   <= 1'b0;
    end else begin
      dec_state_reg <= dec_next;
      bit_cnt_reg   <= bit_cnt_next;
      if (shift_rise & in_opc) begin
        opc_reg <= opc_next;
      end
      if (shift_rise & in_addr) begin
        addr_reg <= addr_next;
      end
      // every bit after the start bit passes here, so the final
      // sixteen received are what a short or long write stores
      if (shift_rise & (in_opc | in_addr | in_data)) begin
        data_reg <= data_next;
      end
      if (en_set) begin
        enabled_reg <= 1'b1;
      end else if (en_clr) begin
        enabled_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command queue toward the programming engine

  sec_prog_if #(.W(CMD_W)) fifo_in ();
  sec_prog_if #(.W(CMD_W)) fifo_out ();

  sec_cmd_t  push_cmd;
  sec_kind_t push_kind;

  // the host is expected to drop select before any further clock rise
  wire armed = (dec_state_reg == D_DATA) | (dec_state_reg == D_FALL);
  wire push  = sel_fall & armed & fifo_in.ready;

  // kind from the held opcode and upper address bits
  assign push_kind = (opc_reg == OPC_WRITE) ? PK_WRITE :
                     (opc_reg == OPC_ERASE) ? PK_ERASE :
                     (sub_held == SUB_FILL) ? PK_FILL : PK_CLEAR;
  assign push_cmd  = '{kind: push_kind, addr: addr_reg, data: data_reg};

  // a full queue drops the command rather than stalling the host
  assign fifo_in.valid = sel_fall & armed;
  assign fifo_in.data  = push_cmd;

  sec_fifo #(
    .W     (CMD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk   (core_clk),
    .rst   (sys_rst),
    .in_p  (fifo_in),
    .out_p (fifo_out)
  );

  ////////////////////////////////////////////////////////////////////////
  // self-timed programming engine

  sec_eng_t          eng_state_reg;
  sec_eng_t          eng_next;
  sec_cmd_t          eng_cmd_reg;
  sec_cmd_t          head_cmd;
  logic [ADDR_W-1:0] eng_addr_reg;
  logic [31:0]       eng_timer_reg;

  assign head_cmd = sec_cmd_t'(fifo_out.data);

  // engine only drains the queue when idle; a full queue drops further commands
  assign fifo_out.ready = eng_state_reg == E_IDLE;
  wire pop       = fifo_out.valid & fifo_out.ready;
  wire eng_all   = (eng_cmd_reg.kind == PK_FILL) |
                   (eng_cmd_reg.kind == PK_CLEAR);
  wire head_all  = (head_cmd.kind == PK_FILL) |
                   (head_cmd.kind == PK_CLEAR);
  wire eng_prog  = (eng_cmd_reg.kind == PK_WRITE) |
                   (eng_cmd_reg.kind == PK_FILL);
  wire sweep_end = ~eng_all | (eng_addr_reg == ADDR_LAST);
  wire time_up   = eng_timer_reg == PROG_LAST;
  wire [ADDR_W-1:0] start_addr = eng_all ? ADDR_FIRST : eng_cmd_reg.addr;

  // write port: erased pattern first, data after the cell time
  wire                mem_we    = (eng_state_reg == E_ERASE) |
                                  (eng_state_reg == E_PROG);
  wire [WORD_W-1:0]   mem_wdata = (eng_state_reg == E_ERASE) ?
                                  ERASED_WORD : eng_cmd_reg.data;

  // engine sequencing
  always_comb begin
    eng_next = eng_state_reg;
    case (eng_state_reg)
      E_IDLE: begin
        if (pop) begin
          eng_next = E_ERASE;
        end
      end
      E_ERASE: begin
        if (sweep_end) begin
          eng_next = E_WAIT;
        end
      end
      E_WAIT: begin
        if (time_up) begin
          eng_next = eng_prog ? E_PROG : E_IDLE;
        end
      end
      E_PROG: begin
        if (sweep_end) begin
          eng_next = E_IDLE;
        end
      end
      default: begin
        eng_next = E_IDLE;
      end
    endcase
  end

  // engine registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      eng_state_reg <= E_IDLE;
      eng_cmd_reg   <= '0;
      eng_addr_reg  <= '0;
      eng_timer_reg <= 32'h0;
    end else begin
      eng_state_reg <= eng_next;
      if (pop) begin
        eng_cmd_reg  <= head_cmd;
        eng_addr_reg <= head_all ? ADDR_FIRST : head_cmd.addr;
      end else if (mem_we) begin
        eng_addr_reg <= sweep_end ? start_addr : eng_addr_reg + 6'h01;
      end
      eng_timer_reg <= (eng_state_reg == E_WAIT) ?
                       eng_timer_reg + 32'h1 : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path with auto increment

  logic [ADDR_W-1:0] rd_addr_reg;
  logic [WORD_W-1:0] rd_shift_reg;
  logic [3:0]        rd_cnt_reg;
  logic [1:0]        rd_pend_reg;
  logic [WORD_W-1:0] mem_rdata;

  // last bit of a word leaves: fetch the next one while select holds
  wire rd_shift = shift_rise & in_read;
  wire rd_wrap  = rd_shift & (rd_cnt_reg == WORD_END);
  wire rd_req   = rd_start | rd_wrap;

  sec_mem #(
    .W     (WORD_W),
    .DEPTH (WORDS),
    .AW    (ADDR_W)
  ) u_mem (
    .clk   (core_clk),
    .rst   (sys_rst),
    .we    (mem_we),
    .waddr (eng_addr_reg),
    .wdata (mem_wdata),
    .raddr (rd_addr_reg),
    .rdata (mem_rdata)
  );

  // address, fetch pipeline and shift register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rd_addr_reg  <= '0;
      rd_shift_reg <= '0;
      rd_cnt_reg   <= 4'h0;
      rd_pend_reg  <= 2'h0;
    end else begin
      rd_pend_reg <= {rd_pend_reg[0], rd_req};
      if (rd_start) begin
        rd_addr_reg <= addr_next;
      end else if (rd_wrap) begin
        rd_addr_reg <= rd_addr_reg + 6'h01;
      end
      if (rd_pend_reg[1]) begin
        rd_shift_reg <= mem_rdata;
        rd_cnt_reg   <= 4'h0;
      end else if (rd_shift) begin
        rd_shift_reg <= {rd_shift_reg[WORD_W-2:0], 1'b0};
        rd_cnt_reg   <= rd_cnt_reg + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ready/busy status and serial output

  // status appears once select is back high and the age has run out
  wire status_ok = status_show_reg & (status_age_reg == STATUS_END) &
                   (dec_state_reg == D_IDLE);

  // read data wins; status is shown only between instructions
  wire out_next = rd_start ? DUMMY_BIT :
                  rd_shift ? rd_shift_reg[WORD_W-1] :
                  in_read  ? serial_out :
                  status_ok ? ~busy_reg : 1'b0;
  wire oe_next  = sel_s2_reg & (rd_start | in_read | status_ok);

  // status flag, its age counter, and the pin registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      status_show_reg <= 1'b0;
      status_age_reg  <= 4'h0;
      busy_reg        <= 1'b0;
      serial_out      <= 1'b0;
      serial_out_oe   <= 1'b0;
      prog_enabled    <= 1'b0;
      prog_busy       <= 1'b0;
    end else begin
      if (push) begin
        status_show_reg <= 1'b1;
      end else if (start_bit) begin
        status_show_reg <= 1'b0;
      end
      if (push) begin
        status_age_reg <= 4'h0;
      end else if (status_age_reg != STATUS_END) begin
        status_age_reg <= status_age_reg + 4'h1;
      end
      busy_reg      <= (eng_state_reg != E_IDLE) | fifo_out.valid | push;
      serial_out    <= out_next;
      serial_out_oe <= oe_next;
      prog_enabled  <= enabled_reg;
      prog_busy     <= busy_reg;
    end
  end
endmodule : sec_port

// [sec_port_properties.sv]
`timescale 1ns/1ns
module sec_port_properties #(
  parameter int PROG_NS = 2000000
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // serial pins
  input wire logic select_pin,
  input wire logic shift_clock,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  // observation outputs
  input wire logic prog_enabled,
  input wire logic prog_busy
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////
  // status window: select raised while the engine still works
  sequence sel_while_busy;
    $rose(select_pin) ##0 prog_busy;
  endsequence
  sequence busy_shown;
    ##[3:6] (serial_out_oe && !serial_out);
  endsequence

  ////////////////////////////////////////////////////////////////////////
  // reset is checked through its own cycles, so no disable here
  a_reset_quiet: assert property (@(posedge core_clk) disable iff (1'b0)
    sys_rst |=> !serial_out_oe && !prog_enabled && !prog_busy)
    else $error("outputs not quiet after reset");
  a_status_busy: assert property (sel_while_busy |-> busy_shown)
    else $error("busy status not shown");
  a_oe_drop: assert property (!select_pin [*5] |-> !serial_out_oe)
    else $error("output driven without select");
  a_oe_rise_sel: assert property ($rose(serial_out_oe) |-> select_pin)
    else $error("output enabled while deselected");
  // a still shift clock must freeze the output once status has settled
  a_out_hold: assert property (
    (select_pin && !prog_busy && $stable(shift_clock)) [*8]
    |-> $stable(serial_out))
    else $error("output moved without a clock rise");
  a_busy_locked: assert property (
    !prog_enabled && !prog_busy |=> !prog_busy)
    else $error("programming while disabled");
  a_enable_at_bit: assert property (
    $changed(prog_enabled) |-> select_pin && shift_clock)
    else $error("enable latch moved outside an instruction");
  a_busy_after_fall: assert property ($rose(prog_busy) |-> !select_pin)
    else $error("programming started with select high");
endmodule : sec_port_properties

// [sec_host.sv]
`timescale 1ns/1ns
module sec_host (
  // clock
  input  wire logic core_clk,
  // lines to the device
  output logic      select_pin,
  output logic      shift_clock,
  output logic      serial_in,
  // line from the device
  input  wire logic serial_out
);
  // idle bus: deselected, shift clock standing low
  initial begin
    select_pin  = 1'h0;
    shift_clock = 1'h0;
    serial_in   = 1'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  // one bit: 8 cycles low then 8 high, wide enough for the synchronisers
  task automatic bit_io(input logic b, output logic so);
    @(posedge core_clk);
    shift_clock <= 1'h0;
    serial_in   <= b;
    tick(8);
    shift_clock <= 1'h1;
    tick(8);
    #1 so = serial_out;
  endtask : bit_io

  // data low on select rise so status is never cleared by accident
  task automatic open_frame();
    @(posedge core_clk);
    select_pin <= 1'h1;
    serial_in  <= 1'h0;
    tick(8);
    #1;
  endtask : open_frame

  // msb first, start bit and opcode included in v
  task automatic send(input int n, input logic [31:0] v);
    logic so;
    for (int i = n - 1; i >= 0; i--) begin
      bit_io(v[i], so);
    end
  endtask : send

  // select drops before any further rise; long gap covers status age
  task automatic close_frame();
    @(posedge core_clk);
    shift_clock <= 1'h0;
    serial_in   <= 1'h0;
    tick(4);
    select_pin  <= 1'h0;
    tick(24);
    #1;
  endtask : close_frame
endmodule : sec_host

// [sec_port_tb.sv]
`timescale 1ns/1ns
module sec_port_tb;
  import sec_pkg::*;
  localparam int PROG = 2000;
  logic core_clk;
  logic sys_rst;
  logic select_pin;
  logic shift_clock;
  logic serial_in;
  logic serial_out;
  logic serial_out_oe;
  logic prog_enabled;
  logic prog_busy;
  int   err_count;
  int   n_checks;

  ////////////////////////////////////////////////////////////////////////
  // short programming time: a hundred-cycle cell wait keeps each poll under 400 cycles
  sec_port #(.PROG_NS(PROG)) i_sec_port (
    .core_clk(core_clk), .sys_rst(sys_rst), .select_pin(select_pin),
    .shift_clock(shift_clock), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .prog_enabled(prog_enabled), .prog_busy(prog_busy));
  sec_host i_sec_host (
    .core_clk(core_clk), .select_pin(select_pin),
    .shift_clock(shift_clock), .serial_in(serial_in),
    .serial_out(serial_out));

  // 50 MHz clock
  always #10 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [WORD_W-1:0] seen,
                       input logic [WORD_W-1:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic cmd(input int n, input logic [31:0] v);
    i_sec_host.open_frame();
    i_sec_host.send(n, v);
    i_sec_host.close_frame();
  endtask : cmd

  // busy first, then ready within a bounded wait
  task automatic poll();
    int k;
    i_sec_host.open_frame();
    check(serial_out_oe, 1'h1);
    check(serial_out, 1'h0);
    for (k = 0; k < 400 && serial_out !== 1'h1; k++) begin
      @(posedge core_clk) #1;
    end
    check(serial_out, 1'h1);
    if (serial_out !== 1'h1) begin
      test_done();
    end
    i_sec_host.close_frame();
    check(prog_busy, 1'h0);
  endtask : poll

  // read two words in one frame: dummy zero, word a, then word a+1
  task automatic read_pair(input logic [5:0] a, input logic [15:0] e0,
                           input logic [15:0] e1);
    logic [31:0] got;
    logic        so;
    i_sec_host.open_frame();
    i_sec_host.send(9, 32'({3'h6, a}));
    check(serial_out_oe, 1'h1);
    check(serial_out, DUMMY_BIT);
    for (int i = 31; i >= 0; i--) begin
      i_sec_host.bit_io(1'h0, so);
      got[i] = so;
    end
    check(got[31:16], e0);
    check(got[15:0], e1);
    i_sec_host.close_frame();
    check(serial_out_oe, 1'h0);
  endtask : read_pair

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    err_count = 0;
    n_checks  = 0;
    core_clk  = 1'h0;
    sys_rst   = 1'h1;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'h0;
    @(posedge core_clk) #1;
    check(prog_enabled, 1'h0);
    cmd(25, 32'({3'h5, 6'h01, 16'h1234}));
    check(prog_busy, 1'h0);
    cmd(9, 32'({3'h4, 6'h30}));
    check(prog_enabled, 1'h1);
    cmd(9, 32'({3'h4, 6'h20}));
    poll();
    read_pair(ADDR_LAST, ERASED_WORD, ERASED_WORD);
    // the read's start bit has cleared the status indication
    i_sec_host.open_frame();
    check(serial_out_oe, 1'h0);
    i_sec_host.close_frame();
    // eighteen data bits: only the final sixteen count
    cmd(27, 32'({3'h5, 6'h3F, 2'h3, 16'hA5C3}));
    poll();
    read_pair(ADDR_LAST, 16'hA5C3, ERASED_WORD);
    cmd(25, 32'({3'h4, 6'h10, 16'h5A0F}));
    poll();
    cmd(9, 32'({3'h7, 6'h05}));
    poll();
    read_pair(6'h04, 16'h5A0F, ERASED_WORD);
    cmd(9, 32'({3'h4, 6'h00}));
    check(prog_enabled, 1'h0);
    cmd(9, 32'({3'h7, 6'h04}));
    check(prog_busy, 1'h0);
    // half a read abandoned, then a fresh one must decode cleanly
    cmd(5, 32'h18);
    read_pair(6'h04, 16'h5A0F, ERASED_WORD);
    test_done();
  end
endmodule : sec_port_tb

bind sec_port sec_port_properties #(.PROG_NS(PROG_NS)) i_sec_port_properties (
  .core_clk(core_clk), .sys_rst(sys_rst), .select_pin(select_pin),
  .shift_clock(shift_clock), .serial_in(serial_in),
  .serial_out(serial_out), .serial_out_oe(serial_out_oe),
  .prog_enabled(prog_enabled), .prog_busy(prog_busy));
